//--- mgp_pkg.sv
// package: register map, field layout and timing figures of the metering control bank
package mgp_pkg;
  // ==========================================================
  // register indexes; byte address is four times the index
  localparam logic [15:0] MGP_IDX_PATH_CTRL3 = 16'h287A;
  localparam logic [15:0] MGP_IDX_PHC_CTRL1 = 16'h287B;
  localparam logic [15:0] MGP_IDX_PHC_CTRL2 = 16'h287C;
  localparam logic [15:0] MGP_IDX_NO_LOAD = 16'h287F;
  localparam logic [15:0] MGP_IDX_IRQ_STATUS = 16'h2880;
  localparam logic [15:0] MGP_IDX_IRQ_MASK = 16'h2881;
  // ==========================================================
  // path control three fields
  localparam int MGP_ZC_EN_BIT = 7;
  localparam int MGP_BPF_EN_BIT = 6;
  localparam int MGP_VQUART_BIT = 5;
  localparam int MGP_E2_SEL_BIT = 4;
  localparam int MGP_I2_SIGN_BIT = 3;
  localparam int MGP_I2_EXP_LSB = 0;
  localparam int MGP_EXP_W = 3;
  localparam logic [2:0] MGP_EXP_MAX = 3'h5;
  // ==========================================================
  // phase compensation fields
  localparam int MGP_PHC_TARGET_BIT = 7;
  localparam logic [7:0] MGP_PHC_MASK = 8'hBF;
  localparam int MGP_COARSE_W = 6;
  localparam int MGP_FINE_W = 2;
  localparam int MGP_FINE_A_LSB = 0;
  localparam int MGP_FINE_B_LSB = 2;
  localparam logic [7:0] MGP_NO_LOAD_MASK = 8'h0F;
  // ==========================================================
  // reset values
  localparam logic [7:0] MGP_RST_PATH_CTRL3 = 8'h00;
  localparam logic [7:0] MGP_RST_PHC_CTRL1 = 8'h00;
  localparam logic [7:0] MGP_RST_PHC_CTRL2 = 8'h00;
  localparam logic [7:0] MGP_RST_NO_LOAD = 8'h00;
  // ==========================================================
  // interrupt status layout
  localparam int MGP_IRQ_W = 2;
  localparam int MGP_IRQ_ZC_BIT = 0;
  localparam int MGP_IRQ_BADEXP_BIT = 1;
  // ==========================================================
  // phase step figures: sample rate in Hz, resolution and span in micro-degrees
  localparam int MGP_PHC_FSMPL_HZ = 3276800;
  localparam int MGP_PHC_STEP_UDEG = 5500;
  localparam int MGP_PHC_SPAN_UDEG = 1400000;
  localparam int MGP_PHC_STEPS = 1 << (MGP_COARSE_W + MGP_FINE_W);
  localparam int MGP_PHC_SPAN_STEPS = MGP_PHC_SPAN_UDEG / MGP_PHC_STEP_UDEG;
  // ==========================================================
  // bus answer timing in core clocks
  localparam int MGP_BUS_WAIT_CYC = 1;
  typedef enum logic [1:0] {MGP_BUS_IDLE, MGP_BUS_ACK, MGP_BUS_DONE} mgp_bus_state_t;
endpackage

//--- mgp_sample_gain.sv
// registered power-of-two gain stage with sign and optional quarter scaling
`timescale 1ns/1ps
`default_nettype none
module mgp_sample_gain
  import mgp_pkg::*;
#(
  parameter int W = 24
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic signed [W-1:0] sample_in,
  input wire logic gain_negative,
  input wire logic [MGP_EXP_W-1:0] gain_exp,
  input wire logic quarter,
  output var logic signed [W+4:0] sample_out_q
);
  // elaboration check: the shift and quarter steps need a few bits
  if (W < 4) begin : g_bad_w
    $error("mgp_sample_gain: W too small");
  end

  // clamp exponent to the top legal value
  logic [MGP_EXP_W-1:0] exp_c;
  logic signed [W+4:0] ext;
  logic signed [W+4:0] shifted;
  logic signed [W+4:0] scaled;
  always_comb begin
    exp_c = (gain_exp > MGP_EXP_MAX) ? MGP_EXP_MAX : gain_exp;
    ext = (W+5)'(sample_in);
    shifted = ext <<< exp_c;
    scaled = quarter ? (shifted >>> 2) : shifted;
  end

  // output register with sign selection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_out_q <= '0;
    end else begin
      sample_out_q <= gain_negative ? -scaled : scaled;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // sampled reset keeps the release edge out: the flop is still cleared there
  property p_gain_sign;
    !sys_rst && !gain_negative && !quarter && gain_exp == 3'h0
      |=> sample_out_q == $past(ext);
  endproperty
  a_gain_sign: assert property (p_gain_sign) else $error("positive unit gain wrong");
  property p_gain_neg;
    !sys_rst && gain_negative && !quarter && gain_exp == 3'h1
      |=> sample_out_q == -($past(ext) <<< 1);
  endproperty
  a_gain_neg: assert property (p_gain_neg) else $error("negative gain wrong");
endmodule
`default_nettype wire

//--- mgp_phase_delay.sv
// one phase compensation channel: routes the 8-bit delay to voltage or current
`timescale 1ns/1ps
`default_nettype none
module mgp_phase_delay
  import mgp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic delay_target,
  input wire logic [MGP_COARSE_W-1:0] coarse_delay,
  input wire logic [MGP_FINE_W-1:0] fine_delay,
  output var logic [7:0] volt_delay_q,
  output var logic [7:0] cur_delay_q
);
  // coarse bits on top, fine bits below
  logic [7:0] full_delay;
  assign full_delay = {coarse_delay, fine_delay};

  // only the selected signal is delayed
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      volt_delay_q <= '0;
      cur_delay_q <= '0;
    end else begin
      volt_delay_q <= delay_target ? full_delay : 8'h00;
      cur_delay_q <= delay_target ? 8'h00 : full_delay;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_one_side;
    (volt_delay_q == 8'h00) || (cur_delay_q == 8'h00);
  endproperty
  a_one_side: assert property (p_one_side) else $error("both signals delayed");
  property p_concat;
    ##1 $past(delay_target) |-> volt_delay_q == {$past(coarse_delay), $past(fine_delay)};
  endproperty
  a_concat: assert property (p_concat) else $error("delay value not concatenated");
endmodule
`default_nettype wire

//--- mgp_metering_ctrl.sv
// metering gain and phase control bank with Avalon-MM slave and interrupt
// Operation
// - zero-crossing interrupt reaches the processor only while its enable bit is one.
// - band-pass filter in RMS paths is used when its enable bit is one.
// - quarter bit set gives the voltage channel a quarter of its configured gain.
// - select bit zero: second path computes reactive power from I1, sign inverted.
// - select bit one: second path computes active power and energy from I2.
// - I2 gain sign bit zero is positive gain, one is negative gain.
// - I2 gain is two to the three-bit exponent; software uses zero to five.
// - channel A delays voltage when target bit is one, else current I1.
// - channel A delay is six coarse bits above two fine no-load bits.
// - at 3.2768 MHz each delay step is 0.0055 degrees, span 1.4 degrees.
// - channel B delays voltage when target bit is one, else current I2.
// - channel B delay is six coarse bits above its two fine no-load bits.
// - any system reset returns all these control registers to defaults.
`timescale 1ns/1ps
`default_nettype none
module mgp_metering_ctrl
  import mgp_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  input wire logic zero_cross_event,
  output var logic irq,
  output var logic rms_bandpass_enable,
  output var logic e2_active_from_i2,
  output var logic e2_reactive_invert,
  input wire logic signed [SAMPLE_W-1:0] voltage_sample,
  input wire logic volt_gain_negative,
  input wire logic [2:0] volt_gain_exp,
  output var logic signed [SAMPLE_W+4:0] voltage_scaled,
  input wire logic signed [SAMPLE_W-1:0] i2_sample,
  output var logic signed [SAMPLE_W+4:0] i2_scaled,
  output var logic [7:0] chan_a_volt_delay,
  output var logic [7:0] chan_a_i1_delay,
  output var logic [7:0] chan_b_volt_delay,
  output var logic [7:0] chan_b_i2_delay
);
  // elaboration checks on the sample width and the delay span
  if (SAMPLE_W < 4 || SAMPLE_W > 26) begin : g_bad_w
    $error("mgp_metering_ctrl: SAMPLE_W out of range");
  end
  if (MGP_PHC_STEPS * MGP_PHC_STEP_UDEG < MGP_PHC_SPAN_UDEG) begin : g_bad_span
    $error("delay span too short");
  end

  // ==========================================================
  // address decode helpers
  function automatic logic [15:0] reg_addr(input logic [15:0] idx);
    reg_addr = {idx[13:0], 2'b00};
  endfunction

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
    hit = (addr == reg_addr(idx));
  endfunction

  // ==========================================================
  // registers
  logic [7:0] path_ctrl3_q;
  logic [7:0] phc_ctrl1_q;
  logic [7:0] phc_ctrl2_q;
  logic [7:0] no_load_q;
  logic [MGP_IRQ_W-1:0] irq_status_q;
  logic [MGP_IRQ_W-1:0] irq_mask_q;
  mgp_bus_state_t bus_state_q;
  logic [31:0] rdata_d;
  logic wr_commit;
  logic [7:0] wbyte;
  logic bad_exp_event;
  logic [MGP_IRQ_W-1:0] irq_eff_mask;
  logic req;

  assign req = avs_read | avs_write;
  assign wbyte = avs_writedata[7:0];
  // write takes effect only at the edge where waitrequest is seen low
  assign wr_commit = avs_write && (bus_state_q == MGP_BUS_ACK) && avs_byteenable[0];

  // ==========================================================
  // read mux; unmapped and reserved bits read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(avs_address, MGP_IDX_PATH_CTRL3)) begin
      rdata_d[7:0] = path_ctrl3_q;
    end else if (hit(avs_address, MGP_IDX_PHC_CTRL1)) begin
      rdata_d[7:0] = phc_ctrl1_q & MGP_PHC_MASK;
    end else if (hit(avs_address, MGP_IDX_PHC_CTRL2)) begin
      rdata_d[7:0] = phc_ctrl2_q & MGP_PHC_MASK;
    end else if (hit(avs_address, MGP_IDX_NO_LOAD)) begin
      rdata_d[7:0] = no_load_q & MGP_NO_LOAD_MASK;
    end else if (hit(avs_address, MGP_IDX_IRQ_STATUS)) begin
      rdata_d[MGP_IRQ_W-1:0] = irq_status_q;
    end else if (hit(avs_address, MGP_IDX_IRQ_MASK)) begin
      rdata_d[MGP_IRQ_W-1:0] = irq_mask_q;
    end
  end

  // ==========================================================
  // bus handshake: one wait cycle, answer, then one idle cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state_q <= MGP_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      unique case (bus_state_q)
        MGP_BUS_IDLE: begin
          if (req) begin
            bus_state_q <= MGP_BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rdata_d : 32'h0000_0000;
          end
        end
        MGP_BUS_ACK: begin
          bus_state_q <= MGP_BUS_DONE;
          avs_waitrequest <= 1'b1;
        end
        MGP_BUS_DONE: begin
          bus_state_q <= MGP_BUS_IDLE;
          avs_readdata <= 32'h0000_0000;
        end
        // unused state code falls back to idle
        default: begin
          bus_state_q <= MGP_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // control registers; all return to defaults on reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      path_ctrl3_q <= MGP_RST_PATH_CTRL3;
      phc_ctrl1_q <= MGP_RST_PHC_CTRL1;
      phc_ctrl2_q <= MGP_RST_PHC_CTRL2;
      no_load_q <= MGP_RST_NO_LOAD;
      irq_mask_q <= '0;
    end else if (wr_commit) begin
      if (hit(avs_address, MGP_IDX_PATH_CTRL3)) path_ctrl3_q <= wbyte;
      if (hit(avs_address, MGP_IDX_PHC_CTRL1)) phc_ctrl1_q <= wbyte & MGP_PHC_MASK;
      if (hit(avs_address, MGP_IDX_PHC_CTRL2)) phc_ctrl2_q <= wbyte & MGP_PHC_MASK;
      if (hit(avs_address, MGP_IDX_NO_LOAD)) no_load_q <= wbyte & MGP_NO_LOAD_MASK;
      if (hit(avs_address, MGP_IDX_IRQ_MASK)) irq_mask_q <= wbyte[MGP_IRQ_W-1:0];
    end
  end

  // ==========================================================
  // interrupt status: sticky, write one to clear, set wins
  assign bad_exp_event = wr_commit && hit(avs_address, MGP_IDX_PATH_CTRL3)
    && (wbyte[MGP_I2_EXP_LSB +: MGP_EXP_W] > MGP_EXP_MAX);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_q <= '0;
    end else begin
      for (int i = 0; i < MGP_IRQ_W; i++) begin
        if ((i == MGP_IRQ_ZC_BIT && zero_cross_event)
            || (i == MGP_IRQ_BADEXP_BIT && bad_exp_event)) begin
          irq_status_q[i] <= 1'b1;
        end else if (wr_commit && hit(avs_address, MGP_IDX_IRQ_STATUS) && wbyte[i]) begin
          irq_status_q[i] <= 1'b0;
        end
      end
    end
  end

  // zero-crossing line also gated by its enable bit
  always_comb begin
    irq_eff_mask = irq_mask_q;
    irq_eff_mask[MGP_IRQ_ZC_BIT] = irq_mask_q[MGP_IRQ_ZC_BIT]
      & path_ctrl3_q[MGP_ZC_EN_BIT];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_eff_mask);
    end
  end

  // ==========================================================
  // datapath mode outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // follow the register defaults so the mode pair never agrees
      rms_bandpass_enable <= MGP_RST_PATH_CTRL3[MGP_BPF_EN_BIT];
      e2_active_from_i2 <= MGP_RST_PATH_CTRL3[MGP_E2_SEL_BIT];
      e2_reactive_invert <= ~MGP_RST_PATH_CTRL3[MGP_E2_SEL_BIT];
    end else begin
      rms_bandpass_enable <= path_ctrl3_q[MGP_BPF_EN_BIT];
      e2_active_from_i2 <= path_ctrl3_q[MGP_E2_SEL_BIT];
      e2_reactive_invert <= ~path_ctrl3_q[MGP_E2_SEL_BIT];
    end
  end

  // ==========================================================
  // gain stages
  mgp_sample_gain #(.W(SAMPLE_W)) u_volt_gain (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sample_in(voltage_sample),
    .gain_negative(volt_gain_negative),
    .gain_exp(volt_gain_exp),
    .quarter(path_ctrl3_q[MGP_VQUART_BIT]),
    .sample_out_q(voltage_scaled)
  );

  mgp_sample_gain #(.W(SAMPLE_W)) u_i2_gain (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sample_in(i2_sample),
    .gain_negative(path_ctrl3_q[MGP_I2_SIGN_BIT]),
    .gain_exp(path_ctrl3_q[MGP_I2_EXP_LSB +: MGP_EXP_W]),
    .quarter(1'b0),
    .sample_out_q(i2_scaled)
  );

  // ==========================================================
  // phase compensation channels; one delay step per sample at the phase rate
  mgp_phase_delay u_chan_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .delay_target(phc_ctrl1_q[MGP_PHC_TARGET_BIT]),
    .coarse_delay(phc_ctrl1_q[MGP_COARSE_W-1:0]),
    .fine_delay(no_load_q[MGP_FINE_A_LSB +: MGP_FINE_W]),
    .volt_delay_q(chan_a_volt_delay),
    .cur_delay_q(chan_a_i1_delay)
  );

  mgp_phase_delay u_chan_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .delay_target(phc_ctrl2_q[MGP_PHC_TARGET_BIT]),
    .coarse_delay(phc_ctrl2_q[MGP_COARSE_W-1:0]),
    .fine_delay(no_load_q[MGP_FINE_B_LSB +: MGP_FINE_W]),
    .volt_delay_q(chan_b_volt_delay),
    .cur_delay_q(chan_b_i2_delay)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_zc_masked;
    !path_ctrl3_q[MGP_ZC_EN_BIT] && !irq_status_q[MGP_IRQ_BADEXP_BIT];
  endsequence
  property p_zc_gate;
    s_zc_masked ##0 s_zc_masked |=> !irq;
  endproperty
  a_zc_gate: assert property (p_zc_gate) else $error("masked zero-cross irq raised");

  property p_bpf;
    ##1 rms_bandpass_enable == $past(path_ctrl3_q[MGP_BPF_EN_BIT]);
  endproperty
  a_bpf: assert property (p_bpf) else $error("band-pass enable not followed");

  property p_e2_mode;
    e2_active_from_i2 != e2_reactive_invert;
  endproperty
  a_e2_mode: assert property (p_e2_mode) else $error("second path mode inconsistent");

  property p_e2_sel;
    ##1 e2_active_from_i2 == $past(path_ctrl3_q[MGP_E2_SEL_BIT]);
  endproperty
  a_e2_sel: assert property (p_e2_sel) else $error("second path select lost");

  property p_reserved_a;
    (phc_ctrl1_q & ~MGP_PHC_MASK) == 8'h00 && (phc_ctrl2_q & ~MGP_PHC_MASK) == 8'h00;
  endproperty
  a_reserved_a: assert property (p_reserved_a) else $error("unused bit stored");

  property p_chan_a;
    ##2 ($past(phc_ctrl1_q, 2) == phc_ctrl1_q && !phc_ctrl1_q[MGP_PHC_TARGET_BIT]
      && $stable(no_load_q)) |-> chan_a_i1_delay == {phc_ctrl1_q[5:0], no_load_q[1:0]};
  endproperty
  a_chan_a: assert property (p_chan_a) else $error("channel A delay wrong");

  property p_chan_b;
    ##2 ($past(phc_ctrl2_q, 2) == phc_ctrl2_q && phc_ctrl2_q[MGP_PHC_TARGET_BIT]
      && $stable(no_load_q)) |-> chan_b_volt_delay == {phc_ctrl2_q[5:0], no_load_q[3:2]};
  endproperty
  a_chan_b: assert property (p_chan_b) else $error("channel B delay wrong");

  sequence s_req_start;
    bus_state_q == MGP_BUS_IDLE && req;
  endsequence
  property p_bus_ans;
    s_req_start |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer timing wrong");

  property p_sticky;
    irq_status_q[MGP_IRQ_ZC_BIT] && !(wr_commit && hit(avs_address, MGP_IDX_IRQ_STATUS))
      |=> irq_status_q[MGP_IRQ_ZC_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit dropped");

  property p_badexp;
    bad_exp_event |=> irq_status_q[MGP_IRQ_BADEXP_BIT];
  endproperty
  a_badexp: assert property (p_badexp) else $error("bad exponent not flagged");
endmodule
`default_nettype wire

//--- tb.sv
// self-checking testbench of the metering gain and phase control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mgp_pkg::*;
  localparam int SW = 24;
  logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq;
  logic zero_cross_event, volt_gain_negative;
  logic rms_bandpass_enable, e2_active_from_i2, e2_reactive_invert;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic signed [SW-1:0] voltage_sample, i2_sample;
  logic [2:0] volt_gain_exp;
  logic signed [SW+4:0] voltage_scaled, i2_scaled;
  logic [7:0] chan_a_volt_delay, chan_a_i1_delay, chan_b_volt_delay, chan_b_i2_delay;
  int fails, checked;
  logic [31:0] seed;
  logic [31:0] rq[$];

  // ==========================================================
  // device under test
  mgp_metering_ctrl #(.SAMPLE_W(SW)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .zero_cross_event(zero_cross_event), .irq(irq),
    .rms_bandpass_enable(rms_bandpass_enable), .e2_active_from_i2(e2_active_from_i2),
    .e2_reactive_invert(e2_reactive_invert), .voltage_sample(voltage_sample),
    .volt_gain_negative(volt_gain_negative), .volt_gain_exp(volt_gain_exp),
    .voltage_scaled(voltage_scaled), .i2_sample(i2_sample), .i2_scaled(i2_scaled),
    .chan_a_volt_delay(chan_a_volt_delay), .chan_a_i1_delay(chan_a_i1_delay),
    .chan_b_volt_delay(chan_b_volt_delay), .chan_b_i2_delay(chan_b_i2_delay)
  );

  // ==========================================================
  // clock, helpers and bus tasks
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wrap_up();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one bus cycle; a read notes its expected byte in the queue
  task automatic bus(input logic rd, input logic [15:0] idx, input logic [7:0] data,
                     input logic [3:0] be);
    int n;
    logic [31:0] r;
    r = rnd();
    @(posedge core_clk);
    if (rd) begin
      rq.push_back({24'h0, data});
    end
    avs_address <= {idx[13:0], 2'h0};
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {r[31:8], data};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      wrap_up();
    end else begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] data);
    bus(1'b0, idx, data, 4'hF);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, exp, 4'hF);
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic reset_check();
    rd(MGP_IDX_PATH_CTRL3, MGP_RST_PATH_CTRL3);
    rd(MGP_IDX_PHC_CTRL1, MGP_RST_PHC_CTRL1);
    rd(MGP_IDX_PHC_CTRL2, MGP_RST_PHC_CTRL2);
    rd(MGP_IDX_NO_LOAD, MGP_RST_NO_LOAD);
    rd(MGP_IDX_IRQ_STATUS, 8'h00);
    rd(MGP_IDX_IRQ_MASK, 8'h00);
    #1;
    check(irq, 1'b0);
    check(e2_reactive_invert, 1'b1);
    check({chan_a_volt_delay, chan_a_i1_delay, chan_b_volt_delay, chan_b_i2_delay}, 0);
  endtask

  // ==========================================================
  // read watcher: takes the oldest note when an answer appears
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (rq.size() == 0) begin
        fails++;
      end else begin
        check(avs_readdata, rq.pop_front());
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [7:0] a1, a2, nl, da, db, c3;
    logic signed [SW-1:0] vs, rs;
    logic signed [SW+4:0] ei, ev;
    seed = 32'hB6F4E761;
    fails = 0;
    checked = 0;
    sys_rst = 1'b1;
    avs_address = 16'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    zero_cross_event = 1'b0;
    volt_gain_negative = 1'b0;
    volt_gain_exp = 3'h0;
    voltage_sample = '0;
    i2_sample = '0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    reset_check();
    // unmapped place reads zero and keeps nothing
    wr(16'h2882, 8'hA5);
    rd(16'h2882, 8'h00);
    // phase compensation: both targets, unused bits, full range
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      a1 = r[7:0];
      a2 = r[15:8];
      nl = r[23:16];
      a1[7] = k[0];
      a2[7] = k[1];
      if (k == 7) begin
        a1[5:0] = 6'h3F;
        a2[5:0] = 6'h3F;
        nl[3:0] = 4'hF;
      end
      wr(MGP_IDX_PHC_CTRL1, a1);
      wr(MGP_IDX_PHC_CTRL2, a2);
      wr(MGP_IDX_NO_LOAD, nl);
      rd(MGP_IDX_PHC_CTRL1, a1 & MGP_PHC_MASK);
      rd(MGP_IDX_PHC_CTRL2, a2 & MGP_PHC_MASK);
      rd(MGP_IDX_NO_LOAD, nl & MGP_NO_LOAD_MASK);
      #1;
      da = {a1[5:0], nl[1:0]};
      db = {a2[5:0], nl[3:2]};
      check(chan_a_volt_delay, a1[7] ? da : 8'h00);
      check(chan_a_i1_delay, a1[7] ? 8'h00 : da);
      check(chan_b_volt_delay, a2[7] ? db : 8'h00);
      check(chan_b_i2_delay, a2[7] ? 8'h00 : db);
    end
    // a write without its low byte lane is dropped
    bus(1'b0, MGP_IDX_PHC_CTRL1, ~a1, 4'hE);
    rd(MGP_IDX_PHC_CTRL1, a1 & MGP_PHC_MASK);
    // path modes and gain stages, the I2 stage over every legal exponent
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      c3 = r[7:0];
      c3[7] = 1'b0;
      c3[5] = k[1];
      c3[3] = k[0];
      c3[2:0] = 3'(k % 6);
      rs = r[31:8];
      r = rnd();
      vs = r[SW-1:0];
      vs[1:0] = 2'h0;
      wr(MGP_IDX_PATH_CTRL3, c3);
      rd(MGP_IDX_PATH_CTRL3, c3);
      i2_sample <= rs;
      voltage_sample <= vs;
      volt_gain_negative <= r[24];
      volt_gain_exp <= r[27:25];
      settle();
      check(rms_bandpass_enable, c3[6]);
      check(e2_active_from_i2, c3[4]);
      check(e2_reactive_invert, !c3[4]);
      ei = rs;
      ei = ei <<< c3[2:0];
      if (c3[3]) ei = -ei;
      check(i2_scaled, ei);
      ev = vs;
      ev = ev <<< ((r[27:25] > 3'h5) ? 3'h5 : r[27:25]);
      if (r[24]) ev = -ev;
      if (c3[5]) ev = ev >>> 2;
      check(voltage_scaled, ev);
    end
    // exponent beyond five: clamped gain and a flagged event
    wr(MGP_IDX_PATH_CTRL3, 8'h06);
    rd(MGP_IDX_IRQ_STATUS, 8'h02);
    ei = i2_sample;
    settle();
    check(i2_scaled, ei <<< 5);
    wr(MGP_IDX_IRQ_MASK, 8'h02);
    settle();
    check(irq, 1'b1);
    wr(MGP_IDX_IRQ_STATUS, 8'h02);
    settle();
    check(irq, 1'b0);
    // zero crossing held back until the enable bit is set
    wr(MGP_IDX_IRQ_MASK, 8'h01);
    wr(MGP_IDX_PATH_CTRL3, 8'h00);
    @(posedge core_clk);
    zero_cross_event <= 1'b1;
    @(posedge core_clk);
    zero_cross_event <= 1'b0;
    settle();
    check(irq, 1'b0);
    rd(MGP_IDX_IRQ_STATUS, 8'h01);
    wr(MGP_IDX_PATH_CTRL3, 8'h80);
    settle();
    check(irq, 1'b1);
    wr(MGP_IDX_IRQ_MASK, 8'h00);
    settle();
    check(irq, 1'b0);
    wr(MGP_IDX_IRQ_MASK, 8'h01);
    settle();
    check(irq, 1'b1);
    wr(MGP_IDX_IRQ_STATUS, 8'h01);
    settle();
    check(irq, 1'b0);
    rd(MGP_IDX_IRQ_STATUS, 8'h00);
    // second reset in mid-run restores every default
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    reset_check();
    settle();
    wrap_up();
  end
endmodule
`default_nettype wire
